// ### common/ram_port_if.sv
// port between the serial engine and the banked ram store
// no clock inside: both ends run on the core clock
`timescale 1ns/10ps
interface ram_port_if;
  import sac_pkg::*;
  logic [RAM_ADDR_W-1:0] raddr;
  logic [BYTE_W-1:0]     rdata;
  logic                  we;
  logic [RAM_ADDR_W-1:0] waddr;
  logic [BYTE_W-1:0]     wdata;
  modport engine (output raddr, we, waddr, wdata, input rdata);
  modport store  (input raddr, we, waddr, wdata, output rdata);
endinterface

// ### common/sac_pkg.sv
// constants, field layouts and state type of the serial access engine
// assumes a single 100 MHz core clock; serial pins are sampled by it
package sac_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          RADDR_W       = 6;
  localparam int          RAM_ADDR_W    = 9;
  localparam int          RAM_DEPTH     = 368;
  localparam int          REG_W         = 16;
  // header byte layout
  localparam int          HDR_RAM_BIT   = 7;
  localparam int          HDR_DIR_BIT   = 6;
  // second ram address byte layout
  localparam int          A2_BANK_HI    = 7;
  localparam int          A2_BANK_LO    = 6;
  localparam int          A2_DIR_BIT    = 5;
  // register addresses
  localparam logic [5:0]  ADDR_TXQ      = 6'h3e;
  localparam logic [5:0]  ADDR_RXQ      = 6'h3f;
  localparam logic [5:0]  STROBE_MAX    = 6'h0e;
  localparam logic [5:0]  STROBE_NOP    = 6'h00;
  localparam logic [5:0]  STROBE_OSC_ON = 6'h01;
  localparam logic [5:0]  STROBE_FL_TX  = 6'h02;
  localparam logic [5:0]  STROBE_FL_RX  = 6'h03;
  // ram banks
  localparam logic [1:0]  BANK_TXQ      = 2'h0;
  localparam logic [1:0]  BANK_RXQ      = 2'h1;
  localparam logic [1:0]  BANK_SEC      = 2'h2;
  localparam logic [6:0]  SEC_SIZE      = 7'h70;
  // status byte bit positions
  localparam int          ST_OSC        = 6;
  localparam int          ST_UFL        = 5;
  localparam int          ST_CRY        = 4;
  localparam int          ST_TXA        = 3;
  localparam int          ST_LCK        = 2;
  localparam int          ST_SSV        = 1;
  // timing
  localparam int          CLK_FREQ_MHZ  = 100;
  localparam int          SSV_TIME_NS   = 128000;
  localparam int          SSV_CYCLES_DF = (SSV_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_HDR, ST_REG_HI, ST_REG_LO, ST_RAM_A2, ST_RAM_DATA, ST_TXQ, ST_RXQ
  } access_state_t;
endpackage

// ### design/access_ram.sv
// banked byte store: transmit queue, receive queue, security storage
// assumes one write and one registered read per cycle
`timescale 1ns/10ps
module access_ram
  import sac_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  ram_port_if.store port
);
  logic [BYTE_W-1:0] mem [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << RAM_ADDR_W)) begin : g_bad_depth
    $error("access_ram: depth out of range");
  end

  // contents are not reset, they survive a bus reset
  always_ff @(posedge clk_in) begin
    if (port.we && (32'(port.waddr) < DEPTH)) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port.rdata <= 8'h00;
    end else if (32'(port.raddr) < DEPTH) begin
      port.rdata <= mem[port.raddr];
    end else begin
      port.rdata <= 8'h00;
    end
  end
endmodule // access_ram

// ### design/serial_access_engine.sv
// serial slave access engine: status, strobes, registers, queues, ram
// assumes mode-0 style host link much slower than clk_in; core inputs on clk_in
//
// Operation
// - status byte shifts out on header, strobes, first ram byte, tx queue bytes
// - status bit 6 shows oscillator running and stable
// - status bit 5 sticks after tx underflow until flush-tx strobe
// - bits 4,3,2 show crypto busy, transmit active, synthesizer lock
// - bit 1 valid forced once reception enabled for 128 us
// - no-op strobe returns status with no other effect
// - oscillator off: only oscillator-on strobe acts, others ignored
// - strobes other than oscillator-on rejected until oscillator stable
// - strobe executes on final falling clock edge of its byte
// - bank 0 tx queue, bank 1 rx queue, bank 2 security 112 bytes
// - ram moves byte by byte with address auto-increment
// - ram write takes data after second byte; read outputs bytes then
// - ram writes never touch queue counters
// - tx queue port 0x3e write only, rx queue port 0x3f read/write
// - queue and ram access run until chip select rises
// - strobe and register accesses chain under one chip select, header decoded after each
// - chip select high may end a register access early
// - flush strobes empty the transmit and receive queues
// - register access 24 bits msb first: 0, direction, address, 16 data
// - serial input sampled on rising serial clock
// - serial output released while chip select high
`timescale 1ns/10ps
module serial_access_engine
  import sac_pkg::*;
#(
  parameter int SSV_CYCLES = SSV_CYCLES_DF
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // serial link pins
  input  wire logic              chip_select_n_in,
  input  wire logic              serial_clock_in,
  input  wire logic              serial_in_in,
  output logic                   serial_out_out,
  output logic                   serial_out_oe_out,
  // core status
  input  wire logic              osc_stable_in,
  input  wire logic              tx_underflow_in,
  input  wire logic              crypto_busy_in,
  input  wire logic              tx_active_in,
  input  wire logic              synth_lock_in,
  input  wire logic              rx_enabled_in,
  input  wire logic              signal_strength_valid_in,
  // strobes to core
  output logic                   osc_on_strobe_out,
  output logic                   flush_tx_strobe_out,
  output logic                   flush_rx_strobe_out,
  output logic                   cmd_strobe_out,
  output logic [RADDR_W-1:0]     cmd_code_out,
  // register file
  output logic [RADDR_W-1:0]     reg_addr_out,
  input  wire logic [REG_W-1:0]  reg_rd_data_in,
  output logic                   reg_wr_out,
  output logic [REG_W-1:0]       reg_wdata_out,
  // queue ports
  output logic                   txq_wr_out,
  output logic [BYTE_W-1:0]      txq_data_out,
  input  wire logic [BYTE_W-1:0] rxq_data_in,
  output logic                   rxq_rd_out,
  output logic                   rxq_wr_out,
  output logic [BYTE_W-1:0]      rxq_data_out
);
  localparam int CNT_W = $clog2(SSV_CYCLES + 1);

  if (SSV_CYCLES < 1) begin : g_bad_ssv
    $error("serial_access_engine: SSV_CYCLES must be at least 1");
  end

  ram_port_if ram_if ();
  access_ram #(.DEPTH(RAM_DEPTH)) u_ram (.clk_in(clk_in), .rst_n_in(rst_n_in), .port(ram_if.store));

  logic cs_s, sck_s, si_s;
  sync_2ff #(.WIDTH(3), .RST_VAL(3'h4)) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({chip_select_n_in, serial_clock_in, serial_in_in}),
    .sync_out ({cs_s, sck_s, si_s})
  );

  // status group
  logic             ufl_r, ufl_nxt;
  logic [CNT_W-1:0] ssv_cnt_r, ssv_cnt_nxt;
  logic [7:0]       status_w;

  // engine group
  access_state_t         state_r, state_nxt;
  logic                  cs_prev_r, cs_prev_nxt;
  logic                  sck_prev_r, sck_prev_nxt;
  logic [2:0]            bit_cnt_r, bit_cnt_nxt;
  logic [7:0]            rx_sh_r, rx_sh_nxt;
  logic [7:0]            tx_sh_r, tx_sh_nxt;
  logic                  so_r, so_nxt, oe_r, oe_nxt;
  logic                  dir_r, dir_nxt;
  logic [RADDR_W-1:0]    reg_addr_r, reg_addr_nxt;
  logic [REG_W-1:0]      reg_cap_r, reg_cap_nxt, reg_wdata_r, reg_wdata_nxt;
  logic [RAM_ADDR_W-1:0] ram_addr_r, ram_addr_nxt, ram_waddr_r, ram_waddr_nxt;
  logic [7:0]            ram_wdata_r, ram_wdata_nxt, q_data_r, q_data_nxt;
  logic                  ram_ro_r, ram_ro_nxt, ram_we_r, ram_we_nxt;
  logic                  pend_r, pend_nxt;
  logic [RADDR_W-1:0]    code_r, code_nxt;
  logic                  osc_on_r, osc_on_nxt, fl_tx_r, fl_tx_nxt, fl_rx_r, fl_rx_nxt;
  logic                  cmd_r, cmd_nxt, reg_wr_r, reg_wr_nxt;
  logic                  txq_wr_r, txq_wr_nxt, rxq_rd_r, rxq_rd_nxt, rxq_wr_r, rxq_wr_nxt;
  logic                  sck_rise, sck_fall, cs_fall, byte_done;
  logic [7:0]            byte_w, src_w;
  logic                  ram_ok_w;

  assign sck_rise  = !cs_s && sck_s && !sck_prev_r;
  assign sck_fall  = !cs_s && !sck_s && sck_prev_r;
  assign cs_fall   = !cs_s && cs_prev_r;
  assign byte_done = sck_rise && (bit_cnt_r == 3'h7);
  assign byte_w    = {rx_sh_r[6:0], si_s};

  always_comb begin
    status_w         = 8'h00;
    status_w[ST_OSC] = osc_stable_in;
    status_w[ST_UFL] = ufl_r;
    status_w[ST_CRY] = crypto_busy_in;
    status_w[ST_TXA] = tx_active_in;
    status_w[ST_LCK] = synth_lock_in;
    status_w[ST_SSV] = signal_strength_valid_in || (32'(ssv_cnt_r) >= SSV_CYCLES);
  end

  always_comb begin
    // set beats a simultaneous flush
    ufl_nxt = tx_underflow_in ? 1'b1 : (fl_tx_nxt ? 1'b0 : ufl_r);
    ssv_cnt_nxt = ssv_cnt_r;
    if (!rx_enabled_in) begin
      ssv_cnt_nxt = '0;
    end else if (32'(ssv_cnt_r) < SSV_CYCLES) begin
      ssv_cnt_nxt = ssv_cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ufl_r     <= 1'b0;
      ssv_cnt_r <= '0;
    end else begin
      ufl_r     <= ufl_nxt;
      ssv_cnt_r <= ssv_cnt_nxt;
    end
  end

  // banks 0..1 full, bank 2 only up to its size, bank 3 unmapped
  assign ram_ok_w = (ram_addr_r[8:7] != 2'h3) &&
                    ((ram_addr_r[8:7] != BANK_SEC) || (ram_addr_r[6:0] < SEC_SIZE));

  // byte presented on the serial output for the current slot
  always_comb begin
    case (state_r)
      ST_HDR, ST_TXQ: src_w = status_w;
      ST_REG_HI:      src_w = dir_r ? reg_rd_data_in[15:8] : 8'h00;
      ST_REG_LO:      src_w = dir_r ? reg_cap_r[7:0] : 8'h00;
      ST_RAM_DATA:    src_w = ram_ok_w ? ram_if.rdata : 8'h00;
      ST_RXQ:         src_w = dir_r ? rxq_data_in : 8'h00;
      default:        src_w = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;   cs_prev_nxt = cs_s;     sck_prev_nxt = sck_s;
    bit_cnt_nxt = bit_cnt_r; rx_sh_nxt = rx_sh_r;  tx_sh_nxt = tx_sh_r;
    so_nxt = so_r;         oe_nxt = oe_r;          dir_nxt = dir_r;
    reg_addr_nxt = reg_addr_r; reg_cap_nxt = reg_cap_r; reg_wdata_nxt = reg_wdata_r;
    ram_addr_nxt = ram_addr_r; ram_waddr_nxt = ram_waddr_r; ram_wdata_nxt = ram_wdata_r;
    ram_ro_nxt = ram_ro_r; q_data_nxt = q_data_r;  pend_nxt = pend_r;  code_nxt = code_r;
    ram_we_nxt = 1'b0;     osc_on_nxt = 1'b0;      fl_tx_nxt = 1'b0;   fl_rx_nxt = 1'b0;
    cmd_nxt = 1'b0;        reg_wr_nxt = 1'b0;      txq_wr_nxt = 1'b0;
    rxq_rd_nxt = 1'b0;     rxq_wr_nxt = 1'b0;
    if (cs_s) begin
      state_nxt   = ST_HDR;
      bit_cnt_nxt = 3'h0;
      pend_nxt    = 1'b0;
      oe_nxt      = 1'b0;
      so_nxt      = 1'b0;
    end else if (cs_fall) begin
      oe_nxt    = 1'b1;
      tx_sh_nxt = status_w;
      so_nxt    = status_w[7];
    end else if (sck_rise) begin
      rx_sh_nxt   = byte_w;
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (byte_done) begin
        case (state_r)
          ST_HDR: begin
            if (byte_w[HDR_RAM_BIT]) begin
              ram_addr_nxt = {2'h0, byte_w[6:0]};
              state_nxt    = ST_RAM_A2;
            end else if (byte_w[5:0] == ADDR_TXQ) begin
              state_nxt = ST_TXQ;
            end else if (byte_w[5:0] == ADDR_RXQ) begin
              dir_nxt   = byte_w[HDR_DIR_BIT];
              state_nxt = ST_RXQ;
            end else if (!byte_w[HDR_DIR_BIT] && (byte_w[5:0] <= STROBE_MAX)) begin
              pend_nxt = 1'b1;
              code_nxt = byte_w[5:0];
            end else begin
              reg_addr_nxt = byte_w[5:0];
              dir_nxt      = byte_w[HDR_DIR_BIT];
              state_nxt    = ST_REG_HI;
            end
          end
          ST_REG_HI: begin
            if (!dir_r) begin
              reg_cap_nxt[15:8] = byte_w;
            end
            state_nxt = ST_REG_LO;
          end
          ST_REG_LO: begin
            if (!dir_r) begin
              reg_wr_nxt    = 1'b1;
              reg_wdata_nxt = {reg_cap_r[15:8], byte_w};
            end
            state_nxt = ST_HDR;
          end
          ST_RAM_A2: begin
            ram_addr_nxt = {byte_w[A2_BANK_HI:A2_BANK_LO], ram_addr_r[6:0]};
            ram_ro_nxt   = byte_w[A2_DIR_BIT];
            state_nxt    = ST_RAM_DATA;
          end
          ST_RAM_DATA: begin
            // plain store write, queue counters stay untouched
            ram_we_nxt    = !ram_ro_r && ram_ok_w;
            ram_waddr_nxt = ram_addr_r;
            ram_wdata_nxt = byte_w;
            ram_addr_nxt  = {ram_addr_r[8:7], ram_addr_r[6:0] + 7'h01};
          end
          ST_TXQ: begin
            txq_wr_nxt = 1'b1;
            q_data_nxt = byte_w;
          end
          ST_RXQ: begin
            rxq_rd_nxt = dir_r;
            rxq_wr_nxt = !dir_r;
            q_data_nxt = byte_w;
          end
          default: state_nxt = ST_HDR;
        endcase
      end
    end else if (sck_fall) begin
      if (bit_cnt_r == 3'h0) begin
        tx_sh_nxt = src_w;
        so_nxt    = src_w[7];
        if (state_r == ST_REG_HI) begin
          reg_cap_nxt = reg_rd_data_in;
        end
        if (pend_r) begin
          pend_nxt = 1'b0;
          if (osc_stable_in || (code_r == STROBE_OSC_ON)) begin
            case (code_r)
              STROBE_NOP:    cmd_nxt    = 1'b0;
              STROBE_OSC_ON: osc_on_nxt = 1'b1;
              STROBE_FL_TX:  fl_tx_nxt  = 1'b1;
              STROBE_FL_RX:  fl_rx_nxt  = 1'b1;
              default:       cmd_nxt    = 1'b1;
            endcase
          end
        end
      end else begin
        so_nxt = tx_sh_r[~bit_cnt_r];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_HDR;     cs_prev_r <= 1'b1;   sck_prev_r <= 1'b0;
      bit_cnt_r <= 3'h0;     rx_sh_r <= 8'h00;    tx_sh_r <= 8'h00;
      so_r <= 1'b0;          oe_r <= 1'b0;        dir_r <= 1'b0;
      reg_addr_r <= 6'h00;   reg_cap_r <= 16'h0000; reg_wdata_r <= 16'h0000;
      ram_addr_r <= 9'h000;  ram_waddr_r <= 9'h000; ram_wdata_r <= 8'h00;
      ram_ro_r <= 1'b0;      q_data_r <= 8'h00;   pend_r <= 1'b0;  code_r <= 6'h00;
      ram_we_r <= 1'b0;      osc_on_r <= 1'b0;    fl_tx_r <= 1'b0; fl_rx_r <= 1'b0;
      cmd_r <= 1'b0;         reg_wr_r <= 1'b0;    txq_wr_r <= 1'b0;
      rxq_rd_r <= 1'b0;      rxq_wr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;  cs_prev_r <= cs_prev_nxt; sck_prev_r <= sck_prev_nxt;
      bit_cnt_r <= bit_cnt_nxt; rx_sh_r <= rx_sh_nxt; tx_sh_r <= tx_sh_nxt;
      so_r <= so_nxt;        oe_r <= oe_nxt;      dir_r <= dir_nxt;
      reg_addr_r <= reg_addr_nxt; reg_cap_r <= reg_cap_nxt; reg_wdata_r <= reg_wdata_nxt;
      ram_addr_r <= ram_addr_nxt; ram_waddr_r <= ram_waddr_nxt; ram_wdata_r <= ram_wdata_nxt;
      ram_ro_r <= ram_ro_nxt; q_data_r <= q_data_nxt; pend_r <= pend_nxt; code_r <= code_nxt;
      ram_we_r <= ram_we_nxt; osc_on_r <= osc_on_nxt; fl_tx_r <= fl_tx_nxt; fl_rx_r <= fl_rx_nxt;
      cmd_r <= cmd_nxt;      reg_wr_r <= reg_wr_nxt; txq_wr_r <= txq_wr_nxt;
      rxq_rd_r <= rxq_rd_nxt; rxq_wr_r <= rxq_wr_nxt;
    end
  end

  assign ram_if.raddr = ram_addr_r;
  assign ram_if.we    = ram_we_r;
  assign ram_if.waddr = ram_waddr_r;
  assign ram_if.wdata = ram_wdata_r;

  assign serial_out_out      = so_r;
  assign serial_out_oe_out   = oe_r;
  assign osc_on_strobe_out   = osc_on_r;
  assign flush_tx_strobe_out = fl_tx_r;
  assign flush_rx_strobe_out = fl_rx_r;
  assign cmd_strobe_out      = cmd_r;
  assign cmd_code_out        = code_r;
  assign reg_addr_out        = reg_addr_r;
  assign reg_wr_out          = reg_wr_r;
  assign reg_wdata_out       = reg_wdata_r;
  assign txq_wr_out          = txq_wr_r;
  assign txq_data_out        = q_data_r;
  assign rxq_rd_out          = rxq_rd_r;
  assign rxq_wr_out          = rxq_wr_r;
  assign rxq_data_out        = q_data_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_strobe_byte;
    byte_done && (state_r == ST_HDR) && !byte_w[HDR_RAM_BIT] && !byte_w[HDR_DIR_BIT] && (byte_w[5:0] <= STROBE_MAX);
  endsequence
  sequence s_strobe_exec;
    sck_fall && (bit_cnt_r == 3'h0) && pend_r;
  endsequence

  a_so_released: assert property (cs_s |=> !serial_out_oe_out)
    else $error("serial output driven with chip select high");
  a_status_first: assert property (cs_fall |=> serial_out_oe_out && (tx_sh_r == $past(status_w)) &&
      (serial_out_out == $past(status_w[7])))
    else $error("status msb not presented at chip select fall");
  a_ufl_clear: assert property ($fell(ufl_r) |-> flush_tx_strobe_out && !$past(tx_underflow_in))
    else $error("underflow flag cleared without flush strobe");
  a_ufl_set: assert property (tx_underflow_in |=> ufl_r)
    else $error("underflow event lost");
  a_osc_gate: assert property ((cmd_strobe_out || flush_tx_strobe_out || flush_rx_strobe_out) |-> $past(osc_stable_in))
    else $error("strobe acted while oscillator not stable");
  // a sequence cannot be negated, so the exec condition is spelled out here
  a_strobe_timing: assert property (s_strobe_byte ##1
      (!(sck_fall && (bit_cnt_r == 3'h0) && pend_r) && !cs_s)[*8] |-> pend_r)
    else $error("strobe executed before final falling edge");
  a_nop_quiet: assert property ((s_strobe_exec and (code_r == STROBE_NOP)) |=>
      !(osc_on_strobe_out || flush_tx_strobe_out || flush_rx_strobe_out || cmd_strobe_out))
    else $error("no-op strobe had an effect");
  a_ssv_forced: assert property ((32'(ssv_cnt_r) >= SSV_CYCLES) |-> status_w[ST_SSV])
    else $error("signal strength valid missing after wait");
  a_ram_incr: assert property ((byte_done && state_r == ST_RAM_DATA) |=>
      (ram_addr_r[6:0] == $past(ram_addr_r[6:0]) + 7'h01) && (ram_addr_r[8:7] == $past(ram_addr_r[8:7])))
    else $error("ram address did not increment within bank");
  a_cs_abort: assert property (cs_s |=> (bit_cnt_r == 3'h0) && (state_r == ST_HDR) && !pend_r)
    else $error("chip select high did not abort access");
  a_txq_port: assert property (txq_wr_out |-> $past(state_r) == ST_TXQ && !ram_we_r)
    else $error("tx queue write outside queue access");
endmodule // serial_access_engine

// ### design/sync_2ff.sv
// two flip-flop synchroniser for asynchronous pin levels
// assumes each bit is an independent level
`timescale 1ns/10ps
module sync_2ff #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // sync_2ff

// ### sim/host_model.sv
// host controller model driving the serial link of the access engine
// assumes a core clock far faster than the 160 ns link clock
`timescale 1ns/10ps
module host_model (
  // pacing clock
  input  wire logic clk_in,
  // link pins
  input  wire logic serial_out_in,
  output logic      chip_select_n_out,
  output logic      serial_clock_out,
  output logic      serial_in_out
);
  initial begin
    chip_select_n_out = 1'b1;
    serial_clock_out  = 1'b0;
    serial_in_out     = 1'b0;
  end

  // half a link period, 80 ns
  task automatic half();
    repeat (8) @(posedge clk_in);
  endtask

  // data set at the falling edge, held across the rising one
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    chip_select_n_out <= 1'b0;
    half();
    for (int i = 7; i > 7 - nbits; i--) begin
      serial_clock_out <= 1'b0;
      serial_in_out    <= tx[i];
      half();
      rx[i] = serial_out_in;
      serial_clock_out <= 1'b1;
      half();
    end
  endtask

  // trailing falling edge so a pending strobe runs before deselect
  task automatic end_frame();
    serial_clock_out  <= 1'b0;
    serial_in_out     <= ~serial_in_out;
    half();
    chip_select_n_out <= 1'b1;
    half();
    half();
  endtask
endmodule // host_model

// ### sim/serial_access_engine_test.sv
// self-checking bench for the serial access engine with a host model
// assumes the ram store lives inside the engine; core levels come from here
`timescale 1ns/10ps
module serial_access_engine_test;
  import sac_pkg::*;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, osc_stable_in = 1'b0, tx_underflow_in = 1'b0;
  logic        crypto_busy_in = 1'b0, tx_active_in = 1'b0, synth_lock_in = 1'b0;
  logic        rx_enabled_in = 1'b0, signal_strength_valid_in = 1'b0;
  logic [15:0] reg_rd_data_in = 16'h0000, d;
  logic [7:0]  rxq_data_in = 8'h00, rx, b;
  logic [6:0]  off;
  wire         chip_select_n_in, serial_clock_in, serial_in_in, serial_out_out, serial_out_oe_out;
  wire  [5:0]  cmd_code_out, reg_addr_out;
  wire  [15:0] reg_wdata_out;
  wire  [7:0]  txq_data_out, rxq_data_out, pul;
  int          n[8];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          seed = 32'h7d96;

  always #5 clk_in = ~clk_in;

  serial_access_engine #(.SSV_CYCLES(20)) i_serial_access_engine (
    .clk_in, .rst_n_in, .chip_select_n_in, .serial_clock_in, .serial_in_in,
    .serial_out_out, .serial_out_oe_out, .osc_stable_in, .tx_underflow_in, .crypto_busy_in,
    .tx_active_in, .synth_lock_in, .rx_enabled_in, .signal_strength_valid_in,
    .osc_on_strobe_out(pul[0]), .flush_tx_strobe_out(pul[1]), .flush_rx_strobe_out(pul[2]),
    .cmd_strobe_out(pul[3]), .cmd_code_out, .reg_addr_out, .reg_rd_data_in, .reg_wr_out(pul[7]),
    .reg_wdata_out, .txq_wr_out(pul[4]), .txq_data_out, .rxq_data_in, .rxq_rd_out(pul[5]),
    .rxq_wr_out(pul[6]), .rxq_data_out);

  // released output reads high through the pull-up
  host_model i_host_model (.clk_in, .serial_out_in(serial_out_oe_out ? serial_out_out : 1'b1),
    .chip_select_n_out(chip_select_n_in), .serial_clock_out(serial_clock_in),
    .serial_in_out(serial_in_in));

  // pulse tallies per core output
  always @(posedge clk_in) for (int k = 0; k < 8; k++) n[k] += int'(pul[k]);

  function automatic logic [7:0] st(input logic u);
    return {1'b0, osc_stable_in, u, crypto_busy_in, tx_active_in, synth_lock_in,
            rx_enabled_in | signal_strength_valid_in, 1'b0};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic x(input logic [7:0] tx);
    i_host_model.xfer(tx, 8, rx);
  endtask

  task automatic fin();
    i_host_model.end_frame();
    check(16'(serial_out_oe_out), 16'h0000);
  endtask

  // new random core levels, settled well before the next frame
  task automatic levels(input logic o, input logic r);
    osc_stable_in <= o;
    rx_enabled_in <= r;
    {crypto_busy_in, tx_active_in, synth_lock_in, signal_strength_valid_in} <= 4'($random(seed));
    reg_rd_data_in <= 16'($random(seed));
    rxq_data_in <= 8'($random(seed));
    repeat (30) @(posedge clk_in);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_in);
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    levels(1'b0, 1'b0);
    x(8'(STROBE_NOP)); check(rx, st(1'b0));
    x(8'(STROBE_FL_TX)); check(rx, st(1'b0));
    x(8'h04); fin();
    check(16'(n[1] + n[3]), 16'h0000);
    x(8'(STROBE_OSC_ON)); x(8'(STROBE_FL_RX)); fin();
    check(16'(n[0] * 2 + n[2]), 16'h0002);
    $display("test oscillator_off done");
    levels(1'b1, 1'b1);
    @(posedge clk_in) tx_underflow_in <= 1'b1;
    @(posedge clk_in) tx_underflow_in <= 1'b0;
    for (int c = 0; c < 15; c++) begin
      x(8'(c));
      if (c < 3) check(rx, st(1'b1));
    end
    fin();
    check(16'(cmd_code_out), 16'h000e);
    x(8'h00); fin(); check(rx, st(1'b0));
    check(16'(n[1] * 256 + n[2] * 16 + n[3]), 16'h011b);
    $display("test strobe_table done");
    d = 16'($random(seed));
    x(8'h10); x(d[15:8]); x(d[7:0]);
    x(8'h50); x(8'h00); check(rx, reg_rd_data_in[15:8]);
    x(8'h00); check(rx, reg_rd_data_in[7:0]); fin();
    check(reg_wdata_out, d); check(16'(n[7]), 16'h0001);
    check(16'(reg_addr_out), 16'h0010);
    x(8'h50); fin();
    i_host_model.xfer(8'h02, 4, rx); fin();
    x(8'h00); fin(); check(rx, st(1'b0));
    check(16'(n[1]), 16'h0001);
    $display("test registers done");
    x(8'(ADDR_TXQ)); check(rx, st(1'b0));
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      x(b); check(rx, st(1'b0));
    end
    fin(); check(16'(n[4]), 16'h0003); check(16'(txq_data_out), 16'(b));
    x(8'h7f); x(8'h00); check(rx, rxq_data_in); fin();
    x(8'(ADDR_RXQ)); x(~b); fin(); check(16'(n[5] * 16 + n[6]), 16'h0011);
    check(16'(rxq_data_out), {8'h00, ~b});
    $display("test queues done");
    for (int k = 0; k < 3; k++) begin
      off = 7'($random(seed)) % 7'h6e;
      d = 16'($random(seed));
      x({1'b1, off}); check(rx, st(1'b0));
      x({2'(k), 6'h00}); x(d[15:8]); x(d[7:0]); fin();
      x({1'b1, off}); x({2'(k), 6'h20}); x(8'h00); check(rx, d[15:8]);
      x(8'h00); check(rx, d[7:0]); fin();
    end
    check(16'(n[4]), 16'h0003);
    $display("test ram_banks done");
    wrap_up();
  end
endmodule // serial_access_engine_test
